// *** design/prc_top.sv ***
// Overview of operation
// - Read line: code 00 one line, 10 full
// - Line code 01: keep leftover after bridge disconnect
// - Line code 11: keep leftover however burst ended
// - PCI-X mode ignores prefetch mode fields
// - Plain read: 00 line, 10 full, 11 one dword
// - Special bit 0: changed command gets retry
// - Special bit 1: changed command still completes
// - Byte count field limits upstream read size
// - Credit update every two, or every one
// - Sticky retry-expired bit, write one clears
// - Retry limit none, 256, 64K or 2G
// - Short discard drops held data after 64 clocks
// - Read multiple: 00 one line, else full
module prc_top #(
  parameter int DISCARD_CYC = 1024
) (
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RST_B,
  input  wire logic [7:0]  I_REG_ADDR,
  input  wire logic [31:0] I_REG_WDATA,
  input  wire logic        I_REG_WR,
  input  wire logic        I_REG_RD,
  output logic      [31:0] O_REG_RDATA,
  input  wire logic        I_PCIX_MODE,
  input  wire logic        I_RD_REQ,
  input  wire logic [1:0]  I_RD_CMD,
  input  wire logic [31:0] I_RD_ADDR,
  input  wire logic [3:0]  I_RD_BE,
  input  wire logic        I_RD_PREF,
  input  wire logic        I_CPL_READY,
  input  wire logic        I_BURST_END,
  input  wire logic        I_BY_MASTER,
  input  wire logic        I_CREDIT_FREE,
  output logic             O_RD_RETRY,
  output logic             O_RD_DONE,
  output logic             O_FETCH_START,
  output logic      [1:0]  O_FETCH_MODE,
  output logic      [11:0] O_MAX_RD_BYTES,
  output logic             O_DATA_HELD,
  output logic             O_DISCARD,
  output logic             O_RETRY_EXPIRED,
  output logic             O_FC_UPDATE,
  output logic             O_IRQ
);

  if (DISCARD_CYC < 2 || DISCARD_CYC > 65535) begin : g_bad_discard
    $error("prc_top: DISCARD_CYC must lie in 2..65535");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [31:0]                ctrl_reg;
  logic [31:0]                ctrl_next;
  logic                       rstat_reg;
  logic                       rstat_next;
  logic [prc_pkg::IRQ_W-1:0]  irq_stat_reg;
  logic [prc_pkg::IRQ_W-1:0]  irq_stat_next;
  logic [prc_pkg::IRQ_W-1:0]  irq_en_reg;
  logic [prc_pkg::IRQ_W-1:0]  irq_events;
  logic [31:0]                rdata_reg;
  logic [31:0]                rdata_next;
  logic [31:0]                ctrl_view;
  logic                       wr_ctrl;
  logic                       wr_clr;
  logic                       wr_en;
  logic                       rd_ctrl;
  logic                       rd_stat;
  logic                       rd_en;
  logic                       ret_expired;
  logic                       disc_fire;

  assign wr_ctrl = I_REG_WR && (I_REG_ADDR == prc_pkg::ADDR_CTRL);
  assign wr_clr  = I_REG_WR && (I_REG_ADDR == prc_pkg::ADDR_IRQ_CLR);
  assign wr_en   = I_REG_WR && (I_REG_ADDR == prc_pkg::ADDR_IRQ_EN);
  assign rd_ctrl = I_REG_RD && (I_REG_ADDR == prc_pkg::ADDR_CTRL);
  assign rd_stat = I_REG_RD && (I_REG_ADDR == prc_pkg::ADDR_IRQ_STAT);
  assign rd_en   = I_REG_RD && (I_REG_ADDR == prc_pkg::ADDR_IRQ_EN);

  assign ctrl_next = wr_ctrl ? (I_REG_WDATA & prc_pkg::CTRL_RW_MASK) : ctrl_reg;
  // Hardware set wins over a same-cycle write-one clear
  assign rstat_next = ret_expired ||
                      (rstat_reg && !(wr_ctrl && I_REG_WDATA[prc_pkg::RSTAT_BIT]));
  assign ctrl_view = ctrl_reg | ({31'h0000_0000, rstat_reg} << prc_pkg::RSTAT_BIT);

  assign irq_events    = {disc_fire, ret_expired};
  assign irq_stat_next = irq_events |
                         (irq_stat_reg & ~(wr_clr ? I_REG_WDATA[prc_pkg::IRQ_W-1:0] : '0));

  // Unmapped and write-only addresses read as zero
  assign rdata_next = rd_ctrl ? ctrl_view :
                      rd_stat ? {30'h0000_0000, irq_stat_reg} :
                      rd_en   ? {30'h0000_0000, irq_en_reg} :
                                32'h0000_0000;

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_B) begin
      ctrl_reg     <= prc_pkg::CTRL_RESET;
      rstat_reg    <= 1'b0;
      irq_stat_reg <= '0;
      irq_en_reg   <= '0;
      rdata_reg    <= 32'h0000_0000;
    end else begin
      ctrl_reg     <= ctrl_next;
      rstat_reg    <= rstat_next;
      irq_stat_reg <= irq_stat_next;
      irq_en_reg   <= wr_en ? I_REG_WDATA[prc_pkg::IRQ_W-1:0] : irq_en_reg;
      rdata_reg    <= rdata_next;
    end
  end

  assign O_REG_RDATA = rdata_reg;
  assign O_IRQ       = |(irq_stat_reg & irq_en_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Control fields
  logic [1:0]  f_rm;
  logic [1:0]  f_rl;
  logic [1:0]  f_rd;
  logic        f_special;
  logic [2:0]  f_maxbc;
  logic        f_fcu;
  logic [1:0]  f_rlim;
  logic        f_short;
  logic [11:0] max_bytes;
  logic [31:0] retry_limit;

  assign f_rm      = ctrl_reg[prc_pkg::RM_LSB +: 2];
  assign f_rl      = ctrl_reg[prc_pkg::RL_LSB +: 2];
  assign f_rd      = ctrl_reg[prc_pkg::RD_LSB +: 2];
  assign f_special = ctrl_reg[prc_pkg::SPECIAL_BIT];
  assign f_maxbc   = ctrl_reg[prc_pkg::MAXBC_LSB +: 3];
  assign f_fcu     = ctrl_reg[prc_pkg::FCU_BIT];
  assign f_rlim    = ctrl_reg[prc_pkg::RLIM_LSB +: 2];
  assign f_short   = ctrl_reg[prc_pkg::SHORT_BIT];

  // Codes 000, 011 and the rest fall back to 512 bytes
  assign max_bytes = (f_maxbc == 3'h1) ? prc_pkg::BC_128  :
                     (f_maxbc == 3'h2) ? prc_pkg::BC_256  :
                     (f_maxbc == 3'h4) ? prc_pkg::BC_1024 :
                     (f_maxbc == 3'h5) ? prc_pkg::BC_2048 :
                                         prc_pkg::BC_512;

  assign retry_limit = (f_rlim == 2'h1) ? prc_pkg::RLIM_256 :
                       (f_rlim == 2'h2) ? prc_pkg::RLIM_64K :
                       (f_rlim == 2'h3) ? prc_pkg::RLIM_2G  :
                                          32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Delayed read tracking
  prc_pkg::prc_state_e state_reg;
  prc_pkg::prc_state_e state_next;
  logic [31:0] pend_addr_reg;
  logic [3:0]  pend_be_reg;
  logic [1:0]  pend_cmd_reg;
  logic        pend_pref_reg;
  logic [15:0] disc_cnt_reg;
  logic [15:0] disc_limit;
  logic        req_match;
  logic        cmd_ok;
  logic        req_hit;
  logic        accept_new;
  logic        done_pend;
  logic        hold_hit;
  logic        retry_out;
  logic        retry_count;
  logic        keep_data;
  logic [1:0]  keep_sel;
  logic [1:0]  new_mode_sel;
  logic [1:0]  fetch_new;

  assign req_match = (I_RD_ADDR == pend_addr_reg) && (I_RD_BE == pend_be_reg);
  assign cmd_ok    = (I_RD_CMD == pend_cmd_reg) || f_special;
  assign req_hit   = I_RD_REQ && req_match && cmd_ok;

  assign accept_new  = (state_reg == prc_pkg::PRC_IDLE) && I_RD_REQ;
  assign done_pend   = (state_reg == prc_pkg::PRC_PEND) && req_hit && I_CPL_READY;
  assign hold_hit    = (state_reg == prc_pkg::PRC_HOLD) && req_hit;
  // Only requests matching the pending address and byte enables advance the retry count, whatever their command
  assign retry_count = (state_reg == prc_pkg::PRC_PEND) && I_RD_REQ && req_match &&
                       !done_pend;
  assign retry_out   = I_RD_REQ && !done_pend && !hold_hit;

  assign new_mode_sel = (I_RD_CMD == prc_pkg::CMD_LINE) ? f_rl : f_rm;
  // Non-prefetchable reads take only the addressed dword
  assign fetch_new = !I_RD_PREF  ? prc_pkg::FETCH_DW1  :
                     I_PCIX_MODE ? prc_pkg::FETCH_FULL :
                     (I_RD_CMD == prc_pkg::CMD_READ) ?
                       ((f_rd == 2'h2) ? prc_pkg::FETCH_FULL :
                        (f_rd == 2'h3) ? prc_pkg::FETCH_DW1  :
                                         prc_pkg::FETCH_LINE) :
                     (new_mode_sel == 2'h0) ? prc_pkg::FETCH_LINE :
                                              prc_pkg::FETCH_FULL;

  assign keep_sel  = (pend_cmd_reg == prc_pkg::CMD_LINE) ? f_rl :
                     (pend_cmd_reg == prc_pkg::CMD_MULT) ? f_rm : 2'h0;
  assign keep_data = pend_pref_reg && !I_PCIX_MODE &&
                     ((keep_sel == 2'h3) ||
                      ((keep_sel == 2'h1) && !I_BY_MASTER));

  assign disc_limit = f_short ? prc_pkg::SHORT_DISC_CLK : 16'(DISCARD_CYC);
  assign disc_fire  = (state_reg == prc_pkg::PRC_HOLD) && !hold_hit &&
                      (disc_cnt_reg == disc_limit - 16'h0001);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      prc_pkg::PRC_IDLE: begin
        if (I_RD_REQ) begin
          state_next = prc_pkg::PRC_PEND;
        end
      end
      prc_pkg::PRC_PEND: begin
        if (done_pend) begin
          state_next = prc_pkg::PRC_XFER;
        end else if (ret_expired) begin
          state_next = prc_pkg::PRC_IDLE;
        end
      end
      prc_pkg::PRC_XFER: begin
        if (I_BURST_END) begin
          state_next = keep_data ? prc_pkg::PRC_HOLD : prc_pkg::PRC_IDLE;
        end
      end
      prc_pkg::PRC_HOLD: begin
        if (hold_hit) begin
          state_next = prc_pkg::PRC_XFER;
        end else if (disc_fire) begin
          state_next = prc_pkg::PRC_IDLE;
        end
      end
      default: state_next = prc_pkg::PRC_IDLE;
    endcase
  end

  prc_retry_cnt #(
    .W (32)
  ) u_retry_cnt (
    .i_clk     (I_CLK_SYS),
    .i_rst_b   (I_RST_B),
    .i_clear   (accept_new || done_pend),
    .i_retry   (retry_count),
    .i_limit   (retry_limit),
    .o_expired (ret_expired)
  );

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_B) begin
      state_reg     <= prc_pkg::PRC_IDLE;
      pend_addr_reg <= 32'h0000_0000;
      pend_be_reg   <= 4'h0;
      pend_cmd_reg  <= 2'h0;
      pend_pref_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (accept_new) begin
        pend_addr_reg <= I_RD_ADDR;
        pend_be_reg   <= I_RD_BE;
        pend_cmd_reg  <= I_RD_CMD;
        pend_pref_reg <= I_RD_PREF;
      end
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_B || state_reg != prc_pkg::PRC_HOLD) begin
      disc_cnt_reg <= 16'h0000;
    end else begin
      disc_cnt_reg <= disc_cnt_reg + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flow control credit pacing
  logic fc_half_reg;
  logic fc_fire;

  assign fc_fire = I_CREDIT_FREE && (f_fcu || fc_half_reg);

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_B || f_fcu) begin
      fc_half_reg <= 1'b0;
    end else if (I_CREDIT_FREE) begin
      fc_half_reg <= !fc_half_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs, and O_DATA_HELD decoded from state_reg
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_B) begin
      O_RD_RETRY      <= 1'b0;
      O_RD_DONE       <= 1'b0;
      O_FETCH_START   <= 1'b0;
      O_FETCH_MODE    <= prc_pkg::FETCH_LINE;
      O_MAX_RD_BYTES  <= prc_pkg::BC_512;
      O_DISCARD       <= 1'b0;
      O_RETRY_EXPIRED <= 1'b0;
      O_FC_UPDATE     <= 1'b0;
    end else begin
      O_RD_RETRY      <= retry_out;
      O_RD_DONE       <= done_pend || hold_hit;
      O_FETCH_START   <= accept_new;
      O_FETCH_MODE    <= accept_new ? fetch_new : O_FETCH_MODE;
      O_MAX_RD_BYTES  <= accept_new ? max_bytes : O_MAX_RD_BYTES;
      O_DISCARD       <= disc_fire;
      O_RETRY_EXPIRED <= ret_expired;
      O_FC_UPDATE     <= fc_fire;
    end
  end

  assign O_DATA_HELD = (state_reg == prc_pkg::PRC_HOLD);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [15:0] hold_age_reg;
  logic        short_d_reg;

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_B) begin
      hold_age_reg <= 16'h0000;
      short_d_reg  <= 1'b0;
    end else begin
      hold_age_reg <= O_DATA_HELD ? hold_age_reg + 16'h0001 : 16'h0000;
      short_d_reg  <= f_short;
    end
  end

  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_RST_B);

  a_line_one: assert property (
    accept_new && I_RD_CMD == prc_pkg::CMD_LINE && I_RD_PREF && !I_PCIX_MODE && f_rl == 2'h0
    |=> O_FETCH_START && O_FETCH_MODE == prc_pkg::FETCH_LINE)
    else $error("read line code 00 did not fetch one line");
  a_line_full: assert property (
    accept_new && I_RD_CMD == prc_pkg::CMD_LINE && I_RD_PREF && !I_PCIX_MODE && f_rl == 2'h2
    |=> O_FETCH_MODE == prc_pkg::FETCH_FULL)
    else $error("read line code 10 did not prefetch fully");
  a_keep_bridge: assert property (
    state_reg == prc_pkg::PRC_XFER && I_BURST_END && pend_cmd_reg == prc_pkg::CMD_LINE &&
    pend_pref_reg && !I_PCIX_MODE && f_rl == 2'h1
    |=> O_DATA_HELD == !$past(I_BY_MASTER))
    else $error("code 01 leftover kept wrongly");
  a_keep_either: assert property (
    state_reg == prc_pkg::PRC_XFER && I_BURST_END && pend_cmd_reg == prc_pkg::CMD_LINE &&
    pend_pref_reg && !I_PCIX_MODE && f_rl == 2'h3
    |=> O_DATA_HELD)
    else $error("code 11 leftover not kept");
  a_pcix_ignore: assert property (
    accept_new && I_RD_PREF && I_PCIX_MODE |=> O_FETCH_MODE == prc_pkg::FETCH_FULL)
    else $error("prefetch mode not ignored in PCI-X mode");
  a_read_dword: assert property (
    accept_new && I_RD_CMD == prc_pkg::CMD_READ && I_RD_PREF && !I_PCIX_MODE && f_rd == 2'h3
    |=> O_FETCH_MODE == prc_pkg::FETCH_DW1)
    else $error("read code 11 did not stop at first dword");
  a_change_retry: assert property (
    state_reg == prc_pkg::PRC_PEND && I_RD_REQ && req_match && I_RD_CMD != pend_cmd_reg &&
    !f_special |=> O_RD_RETRY && !O_RD_DONE)
    else $error("changed command not retried");
  a_change_done: assert property (
    state_reg == prc_pkg::PRC_PEND && I_RD_REQ && req_match && f_special && I_CPL_READY
    |=> O_RD_DONE && !O_RD_RETRY)
    else $error("special mode read did not complete");
  a_max_bytes: assert property (
    accept_new && f_maxbc == 3'h5 |=> O_MAX_RD_BYTES == prc_pkg::BC_2048)
    else $error("byte count code 101 not 2048");
  a_fc_single: assert property (
    f_fcu && I_CREDIT_FREE |=> O_FC_UPDATE)
    else $error("credit update missing in single mode");
  a_fc_pair: assert property (
    !f_fcu && I_CREDIT_FREE && !fc_half_reg |=> !O_FC_UPDATE)
    else $error("credit update after one credit in pair mode");
  a_status_sticky: assert property (
    rstat_reg && !(wr_ctrl && I_REG_WDATA[prc_pkg::RSTAT_BIT]) |=> rstat_reg)
    else $error("retry status bit lost");
  a_no_limit: assert property (
    f_rlim == 2'h0 |-> !ret_expired)
    else $error("retry expired with no limit");
  a_short_discard: assert property (
    O_DISCARD && short_d_reg |-> hold_age_reg == 16'h0040)
    else $error("short discard not at 64 clocks");
  a_mult_line: assert property (
    accept_new && I_RD_CMD == prc_pkg::CMD_MULT && I_RD_PREF && !I_PCIX_MODE && f_rm == 2'h0
    |=> O_FETCH_MODE == prc_pkg::FETCH_LINE)
    else $error("read multiple code 00 did not fetch one line");
  a_expire_drop: assert property (
    ret_expired |=> state_reg == prc_pkg::PRC_IDLE && O_RETRY_EXPIRED && rstat_reg)
    else $error("expiry did not drop the transaction");

  c_hold_collect: cover property (hold_hit);
  c_discard:      cover property (disc_fire);
  c_expire:       cover property (ret_expired);
  c_special:      cover property (done_pend && I_RD_CMD != pend_cmd_reg);

endmodule

// *** design/prc_pkg.sv ***
package prc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [7:0]  ADDR_CTRL      = 8'h40;
  localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h44;
  localparam logic [7:0]  ADDR_IRQ_CLR   = 8'h48;
  localparam logic [7:0]  ADDR_IRQ_EN    = 8'h4c;

  ////////////////////////////////////////////////////////////////////////////
  // Control word field positions
  localparam int          RM_LSB         = 4;
  localparam int          RL_LSB         = 6;
  localparam int          RD_LSB         = 8;
  localparam int          SPECIAL_BIT    = 10;
  localparam int          MAXBC_LSB      = 12;
  localparam int          FCU_BIT        = 15;
  localparam int          RSTAT_BIT      = 16;
  localparam int          RLIM_LSB       = 17;
  localparam int          SHORT_BIT      = 20;
  localparam logic [31:0] CTRL_RW_MASK   = 32'h0016_f7f0;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt bits
  localparam int          IRQ_W          = 2;
  localparam int          IRQ_EXPIRED    = 0;
  localparam int          IRQ_DISCARD    = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Read command codes on the request port
  localparam logic [1:0]  CMD_READ       = 2'h0;
  localparam logic [1:0]  CMD_LINE       = 2'h1;
  localparam logic [1:0]  CMD_MULT       = 2'h2;

  // Fetch decisions
  localparam logic [1:0]  FETCH_LINE     = 2'h0;
  localparam logic [1:0]  FETCH_FULL     = 2'h1;
  localparam logic [1:0]  FETCH_DW1      = 2'h2;

  // Upstream read byte limits
  localparam logic [11:0] BC_128         = 12'h080;
  localparam logic [11:0] BC_256         = 12'h100;
  localparam logic [11:0] BC_512         = 12'h200;
  localparam logic [11:0] BC_1024        = 12'h400;
  localparam logic [11:0] BC_2048        = 12'h800;

  // Retry expiration limits
  localparam logic [31:0] RLIM_256       = 32'h0000_0100;
  localparam logic [31:0] RLIM_64K       = 32'h0001_0000;
  localparam logic [31:0] RLIM_2G        = 32'h8000_0000;

  // Short discard time, in PCI clocks
  localparam logic [15:0] SHORT_DISC_CLK = 16'h0040;

  typedef enum {PRC_IDLE, PRC_PEND, PRC_XFER, PRC_HOLD} prc_state_e;

endpackage

// *** design/prc_retry_cnt.sv ***
module prc_retry_cnt #(
  parameter int W = 32
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  input  wire logic         i_clear,
  input  wire logic         i_retry,
  input  wire logic [W-1:0] i_limit,
  output logic              o_expired
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_inc;
  logic         hit;

  if (W < 32) begin : g_bad_width
    $error("prc_retry_cnt: W must hold the 2G limit");
  end

  // A zero limit means retries never expire
  assign count_inc = count_reg + {{(W-1){1'b0}}, 1'b1};
  assign hit       = (i_limit != '0) && (count_inc == i_limit);
  assign o_expired = i_retry && hit;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b || i_clear || o_expired) begin
      count_reg <= '0;
    end else if (i_retry) begin
      count_reg <= count_inc;
    end
  end

endmodule

// *** test/prc_link_model.sv ***
module prc_link_model (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_fetch_start,
  input  wire logic        i_expired,
  input  wire logic [15:0] i_delay,
  output logic             o_cpl_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] cnt_reg;
  logic        wait_reg;
  ////////////////////////////////////////////////////////////////////////////
  // Completion arrives a set number of clocks after the upstream request
  always_ff @(posedge i_clk) begin
    if (!i_rst_b || i_expired) begin
      wait_reg    <= 1'b0;
      o_cpl_ready <= 1'b0;
    end else if (i_fetch_start) begin
      wait_reg    <= 1'b1;
      o_cpl_ready <= 1'b0;
      cnt_reg     <= i_delay;
    end else if (wait_reg) begin
      cnt_reg     <= cnt_reg - 16'h1;
      wait_reg    <= (cnt_reg > 16'h1);
      o_cpl_ready <= (cnt_reg <= 16'h1);
    end
  end
endmodule

// *** test/prc_top_tb_top.sv ***
module prc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_b, wr, rd, pcix, req, pref, bend, bym, cfree, cpl;
  logic        retry, done, fstart, held, disc, expd, fcu, irq;
  logic [1:0]  cmd, fmode;
  logic [3:0]  be;
  logic [7:0]  addr;
  logic [11:0] maxb;
  logic [15:0] dly;
  logic [31:0] wdata, rdata, raddr, r, a;
  int          bad_count, num_checks, fcu_cnt, exp_cnt, e0, bc;

  prc_top #(.DISCARD_CYC(8)) i_dut (
    .I_CLK_SYS(clk), .I_RST_B(rst_b), .I_REG_ADDR(addr), .I_REG_WDATA(wdata),
    .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata), .I_PCIX_MODE(pcix),
    .I_RD_REQ(req), .I_RD_CMD(cmd), .I_RD_ADDR(raddr), .I_RD_BE(be), .I_RD_PREF(pref),
    .I_CPL_READY(cpl), .I_BURST_END(bend), .I_BY_MASTER(bym), .I_CREDIT_FREE(cfree),
    .O_RD_RETRY(retry), .O_RD_DONE(done), .O_FETCH_START(fstart), .O_FETCH_MODE(fmode),
    .O_MAX_RD_BYTES(maxb), .O_DATA_HELD(held), .O_DISCARD(disc),
    .O_RETRY_EXPIRED(expd), .O_FC_UPDATE(fcu), .O_IRQ(irq));
  prc_link_model i_link (.i_clk(clk), .i_rst_b(rst_b), .i_fetch_start(fstart),
    .i_expired(expd), .i_delay(dly), .o_cpl_ready(cpl));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (fcu === 1'b1) fcu_cnt++;
    if (expd === 1'b1) exp_cnt++;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("Checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic reg_wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic chk_reg(input string n, input logic [7:0] ad, input logic [31:0] e);
    @(posedge clk);
    addr <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(n, e, rdata);
  endtask
  task automatic attempt(input logic [1:0] c, input logic p);
    @(posedge clk);
    req <= 1'b1;
    cmd <= c;
    pref <= p;
    @(posedge clk);
    req <= 1'b0;
    #1;
  endtask
  // The ready level of the previous transaction is stale until the model sees the new fetch
  task automatic wait_cpl();
    @(posedge clk);
    #1;
    for (int i = 0; i < 3000 && cpl !== 1'b1; i++) @(posedge clk);
    chk("cpl_wait", 1, cpl);
  endtask
  task automatic burst(input logic m);
    for (int i = 0; i < 3000 && cpl !== 1'b1; i++) @(posedge clk);
    @(posedge clk);
    bend <= 1'b1;
    bym <= m;
    @(posedge clk);
    bend <= 1'b0;
    #1;
  endtask
  function automatic logic [1:0] exp_mode(logic [1:0] c, logic [31:0] v, logic p, x);
    logic [1:0] f;
    f = (c == prc_pkg::CMD_READ) ? v[9:8] : (c == prc_pkg::CMD_LINE) ? v[7:6] : v[5:4];
    if (!p) return 2'h2;
    if (x) return 2'h1;
    if (c == prc_pkg::CMD_READ) return (f == 2'h3) ? 2'h2 : (f == 2'h2) ? 2'h1 : 2'h0;
    return (f == 2'h0) ? 2'h0 : 2'h1;
  endfunction
  function automatic logic [11:0] exp_bytes(logic [2:0] f);
    case (f)
      3'h1: return 12'h080;
      3'h2: return 12'h100;
      3'h4: return 12'h400;
      3'h5: return 12'h800;
      default: return 12'h200;
    endcase
  endfunction
  task automatic run(input logic [1:0] c, input logic [31:0] v, input logic x, p, m,
                     input int nr, input logic [15:0] d);
    int n;
    n = 0;
    e0 = exp_cnt;
    reg_wr(prc_pkg::ADDR_CTRL, v);
    pcix <= x;
    dly <= d;
    raddr <= $urandom;
    be <= 4'($urandom);
    attempt(c, p);
    chk("retry", 1, retry);
    chk("fetch_start", 1, fstart);
    chk("fetch_mode", exp_mode(c, v, p, x), fmode);
    if (fmode === 2'h1) chk("max_bytes", exp_bytes(v[14:12]), maxb);
    repeat (nr) attempt(c, p);
    chk("expired", e0, exp_cnt);
    wait_cpl();
    attempt(c, p);
    chk("done", 1, done);
    burst(m);
    if (c == prc_pkg::CMD_LINE)
      chk("held", p && !x && (v[7:6] == 2'h3 || (v[7:6] == 2'h1 && !m)), held);
    while (held === 1'b1 && n < 200) begin
      @(posedge clk);
      #1 n++;
    end
    chk("discard", n > 0, disc);
    if (v[20] && n > 0) chk("short_discard", 1, n >= 60 && n <= 66);
    chk("held_clear", 0, held);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_b, wr, rd, pcix, req, pref, bend, bym, cfree, cmd, be, addr} = '0;
    {wdata, raddr} = '0;
    dly = 16'h1;
    {bad_count, num_checks, fcu_cnt, exp_cnt} = '0;
    void'($urandom(32'h58a02ed3));
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    #1 chk("max_bytes_rst", 32'h200, maxb);
    chk_reg("ctrl_rst", prc_pkg::ADDR_CTRL, 32'h0);
    chk_reg("unmapped", 8'h50, 32'h0);
    r = $urandom & 32'hfffe_ffff;
    reg_wr(prc_pkg::ADDR_CTRL, r);
    chk_reg("ctrl_rw", prc_pkg::ADDR_CTRL, r & prc_pkg::CTRL_RW_MASK);
    reg_wr(prc_pkg::ADDR_IRQ_CLR, 32'h3);
    chk_reg("clr_read", prc_pkg::ADDR_IRQ_CLR, 32'h0);
    for (int i = 0; i < 48; i++) begin
      bc = (i % 7 == 6) ? 7 : i % 7;
      r = {11'h0, i == 22, 4'h0, 1'($urandom), 3'(bc), 2'h0, {3{2'((i / 3) % 4)}}, 4'h0};
      run(2'(i % 3), r, 1'(i / 24), 1'((i / 12) % 2), 1'($urandom), 0, 16'($urandom_range(1, 20)));
    end
    reg_wr(prc_pkg::ADDR_CTRL, 32'h0);
    pcix <= 1'b0;
    attempt(prc_pkg::CMD_LINE, 1'b1);
    wait_cpl();
    attempt(prc_pkg::CMD_MULT, 1'b1);
    chk("changed_cmd", 1, retry);
    reg_wr(prc_pkg::ADDR_CTRL, 32'h400);
    attempt(prc_pkg::CMD_MULT, 1'b1);
    chk("changed_cmd", 1, done);
    burst(1'b1);
    repeat (2) run(prc_pkg::CMD_LINE, 32'h2_0000, 0, 1, 1, 200, 16'd900);
    run(prc_pkg::CMD_READ, 32'h0, 0, 1, 1, 300, 16'd1000);
    reg_wr(prc_pkg::ADDR_IRQ_CLR, 32'h3);
    reg_wr(prc_pkg::ADDR_IRQ_EN, 32'h1);
    reg_wr(prc_pkg::ADDR_CTRL, 32'h2_0000);
    dly <= 16'd2000;
    e0 = exp_cnt;
    repeat (256) attempt(prc_pkg::CMD_READ, 1'b1);
    chk("expired", e0, exp_cnt);
    attempt(prc_pkg::CMD_READ, 1'b1);
    chk("retry", 1, retry);
    repeat (2) @(posedge clk);
    chk("expired", e0 + 1, exp_cnt);
    chk_reg("status_bit", prc_pkg::ADDR_CTRL, 32'h3_0000);
    chk_reg("irq_stat", prc_pkg::ADDR_IRQ_STAT, 32'h1);
    chk("irq", 1, irq);
    reg_wr(prc_pkg::ADDR_IRQ_EN, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq_masked", 0, irq);
    reg_wr(prc_pkg::ADDR_IRQ_EN, 32'h1);
    reg_wr(prc_pkg::ADDR_CTRL, 32'h3_0000);
    chk_reg("status_clr", prc_pkg::ADDR_CTRL, 32'h2_0000);
    reg_wr(prc_pkg::ADDR_IRQ_CLR, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq_clr", 0, irq);
    for (int m = 0; m < 2; m++) begin
      reg_wr(prc_pkg::ADDR_CTRL, 32'(m) << 15);
      fcu_cnt = 0;
      repeat (10) begin
        @(posedge clk);
        cfree <= 1'b1;
        @(posedge clk);
        cfree <= 1'b0;
        repeat ($urandom % 3) @(posedge clk);
      end
      repeat (3) @(posedge clk);
      chk("fc_updates", m ? 10 : 5, fcu_cnt);
    end
    tally_and_finish();
  end
  initial begin
    #(40 * 40000);
    bad_count++;
    tally_and_finish();
  end
endmodule
